// file: verilog/wpca_pkg.sv
// Purpose: Shared constants and types for the watchpoint control access block
// Assumes: 64-bit system register data, four-bit register index
// Notes:   Field positions follow the watchpoint control layout
package wpca_pkg;
    // Exception levels
    localparam logic [1:0] WPCA_EL_USER = 2'h0;
    localparam logic [1:0] WPCA_EL_KERN = 2'h1;
    localparam logic [1:0] WPCA_EL_HYP  = 2'h2;
    localparam logic [1:0] WPCA_EL_MON  = 2'h3;
    // Instruction encoding of the two control register groups
    localparam logic [1:0] WPCA_OP0     = 2'h2;
    localparam logic [2:0] WPCA_OP1     = 3'h0;
    localparam logic [3:0] WPCA_CRN     = 4'h0;
    localparam logic [2:0] WPCA_OP2_BP  = 3'h5;
    localparam logic [2:0] WPCA_OP2_WP  = 3'h7;
    // Trap class for debug register accesses
    localparam logic [5:0] WPCA_EC_DBG  = 6'h18;
    // Field positions
    localparam int WPCA_ESF_BIT  = 29;
    localparam int WPCA_MSK_HI   = 28;
    localparam int WPCA_MSK_LO   = 24;
    localparam int WPCA_WLS_BIT  = 20;
    localparam int WPCA_LBI_HI   = 19;
    localparam int WPCA_LBI_LO   = 16;
    localparam int WPCA_SSF_HI   = 15;
    localparam int WPCA_SSF_LO   = 14;
    localparam int WPCA_HP_BIT   = 13;
    localparam int WPCA_BLS_HI   = 12;
    localparam int WPCA_BLS_LO   = 5;
    localparam int WPCA_ADS_HI   = 4;
    localparam int WPCA_ADS_LO   = 3;
    localparam int WPCA_PF_HI    = 2;
    localparam int WPCA_PF_LO    = 1;
    localparam int WPCA_EN_BIT   = 0;
    // Writable bits without and with the extended state filter
    localparam logic [63:0] WPCA_WMASK_BASE = 64'h0000_0000_1F1F_FFFF;
    localparam logic [63:0] WPCA_WMASK_ESF  = 64'h0000_0000_3F1F_FFFF;
    // Value after reset, architecturally unknown
    localparam logic [63:0] WPCA_RST_VAL    = 64'h0;
    // Smallest legal nonzero mask encoding
    localparam logic [4:0]  WPCA_MSK_MIN    = 5'h03;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [1:0]  op0;
        logic [2:0]  op1;
        logic [3:0]  crn;
        logic [3:0]  index;
        logic [2:0]  op2;
        logic [63:0] wdata;
    } wpca_req_s;

    typedef struct packed {
        logic        valid;
        logic        undef;
        logic        trap;
        logic [1:0]  trap_el;
        logic [5:0]  ec;
        logic        halt;
        logic [63:0] rdata;
    } wpca_rsp_s;
endpackage : wpca_pkg

// file: verilog/wpca_top.sv
// Purpose: Access checks and field logic for debug control registers
// Assumes: One request per cycle from the pipeline, answer one cycle later
// Notes:   Register contents carry no meaning after reset
`timescale 1ns/1ps
module wpca_top #(
    parameter int NUM_BP        = 16,
    parameter int NUM_WP        = 16,
    parameter bit REALM_FEATURE = 1'b0,
    parameter bit MON_PRIO      = 1'b0
) (
    // Clock and reset
    input  wire logic                  ref_clk_i,
    input  wire logic                  sys_rst_i,
    // Register access from the pipeline
    input  wire wpca_pkg::wpca_req_s   req_i,
    input  wire logic [1:0]            current_exception_level_i,
    output wpca_pkg::wpca_rsp_s        rsp_o,
    // Debug configuration
    input  wire logic                  halted_i,
    input  wire logic                  halting_allowed_i,
    input  wire logic                  have_monitor_level_i,
    input  wire logic                  hyp_enabled_i,
    input  wire logic                  secure_debug_disable_i,
    input  wire logic                  monitor_debug_trap_i,
    input  wire logic [1:0]            hypervisor_debug_route_trap_i,
    input  wire logic                  fine_trap_enable_i,
    input  wire logic [1:0]            fine_read_trap_reg_i,
    input  wire logic [1:0]            fine_write_trap_reg_i,
    input  wire logic                  os_lock_flag_i,
    input  wire logic                  halt_on_access_i,
    // Data access to be watched
    input  wire logic                  acc_valid_i,
    input  wire logic [63:0]           acc_addr_i,
    input  wire logic [7:0]            acc_lanes_i,
    input  wire logic                  acc_store_i,
    input  wire logic [1:0]            acc_el_i,
    input  wire logic                  acc_secure_i,
    input  wire logic                  acc_realm_i,
    input  wire logic [NUM_WP*64-1:0]  watch_value_i,
    input  wire logic [15:0]           ctx_match_i,
    output logic [NUM_WP-1:0]          wp_hit_o
);
    import wpca_pkg::*;

    localparam logic [63:0] WMASK = REALM_FEATURE ? WPCA_WMASK_ESF : WPCA_WMASK_BASE;

    logic [63:0] bp_q [NUM_BP];
    logic [63:0] wp_q [NUM_WP];
    wpca_rsp_s   rsp_q, rsp_d;
    logic [NUM_WP-1:0] hit_q, hit_d;

    // Decode
    wire logic enc_ok  = req_i.op0 == WPCA_OP0 && req_i.op1 == WPCA_OP1
                      && req_i.crn == WPCA_CRN;
    wire logic is_bp   = req_i.valid && enc_ok && req_i.op2 == WPCA_OP2_BP;
    wire logic is_wp   = req_i.valid && enc_ok && req_i.op2 == WPCA_OP2_WP;
    wire logic is_acc  = is_bp || is_wp;
    wire logic unimpl  = is_bp ? (32'(req_i.index) >= NUM_BP)
                               : (32'(req_i.index) >= NUM_WP);
    wire logic [1:0] fgt_vec = req_i.write ? fine_write_trap_reg_i : fine_read_trap_reg_i;
    wire logic fgt_bit = is_bp ? fgt_vec[0] : fgt_vec[1];

    // Trap conditions
    wire logic prio_undef = halted_i && have_monitor_level_i && secure_debug_disable_i
                         && MON_PRIO && monitor_debug_trap_i;
    wire logic fgt_trap = hyp_enabled_i && (!have_monitor_level_i || fine_trap_enable_i)
                       && fgt_bit;
    wire logic hdr_trap = hyp_enabled_i && (hypervisor_debug_route_trap_i != 2'h0);
    wire logic mon_trap = have_monitor_level_i && monitor_debug_trap_i;
    wire logic mon_undef = halted_i && secure_debug_disable_i;
    wire logic halt_hit = !os_lock_flag_i && halting_allowed_i && halt_on_access_i;
    wire logic [1:0] cel = current_exception_level_i;
    wire logic lo_hyp   = cel == WPCA_EL_KERN;
    wire logic mid      = cel == WPCA_EL_KERN || cel == WPCA_EL_HYP;

    // Outcome selection, in documented priority
    wire logic o_undef = unimpl || cel == WPCA_EL_USER
                      || (mid && prio_undef)
                      || (mid && !(lo_hyp && (fgt_trap || hdr_trap))
                          && mon_trap && mon_undef);
    wire logic o_trap2 = !o_undef && lo_hyp && (fgt_trap || hdr_trap);
    wire logic o_trap3 = !o_undef && !o_trap2 && mid && mon_trap;
    wire logic o_halt  = !o_undef && !o_trap2 && !o_trap3 && halt_hit;
    wire logic o_do    = is_acc && !o_undef && !o_trap2 && !o_trap3 && !o_halt;
    wire logic do_wr   = o_do && req_i.write;
    wire logic [63:0] rd_mux = is_bp ? bp_q[req_i.index[$clog2(NUM_BP)-1:0]]
                                     : (wp_q[req_i.index[$clog2(NUM_WP)-1:0]] & WMASK);

    always_comb begin
        rsp_d         = '0;
        rsp_d.valid   = is_acc;
        rsp_d.undef   = is_acc && o_undef;
        rsp_d.trap    = is_acc && (o_trap2 || o_trap3);
        rsp_d.trap_el = o_trap3 ? WPCA_EL_MON : WPCA_EL_HYP;
        rsp_d.ec      = rsp_d.trap ? WPCA_EC_DBG : 6'h00;
        rsp_d.halt    = is_acc && o_halt;
        rsp_d.rdata   = (o_do && !req_i.write) ? rd_mux : 64'h0;
        if (!(is_acc && (o_trap2 || o_trap3))) begin
            rsp_d.trap_el = WPCA_EL_USER;
        end
    end

    // Register storage; reset value is only a convenience
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < NUM_BP; i++) begin
                bp_q[i] <= WPCA_RST_VAL;
            end
            for (int i = 0; i < NUM_WP; i++) begin
                wp_q[i] <= WPCA_RST_VAL;
            end
        end else if (do_wr) begin
            if (is_bp) begin
                bp_q[req_i.index[$clog2(NUM_BP)-1:0]] <= req_i.wdata;
            end else begin
                wp_q[req_i.index[$clog2(NUM_WP)-1:0]] <= req_i.wdata & WMASK;
            end
        end
    end

    // Watchpoint evaluation per index
    for (genvar g = 0; g < NUM_WP; g++) begin : g_wp
        wire logic [63:0] wcr  = wp_q[g];
        wire logic [63:0] wvr  = watch_value_i[g*64 +: 64];
        wire logic [4:0]  msk  = wcr[WPCA_MSK_HI:WPCA_MSK_LO];
        wire logic [7:0]  bls  = wcr[WPCA_BLS_HI:WPCA_BLS_LO];
        wire logic [1:0]  ads  = wcr[WPCA_ADS_HI:WPCA_ADS_LO];
        wire logic [1:0]  pf   = wcr[WPCA_PF_HI:WPCA_PF_LO];
        wire logic [1:0]  ssf  = wcr[WPCA_SSF_HI:WPCA_SSF_LO];
        wire logic [3:0]  lbi  = wcr[WPCA_LBI_HI:WPCA_LBI_LO];
        wire logic        esf  = REALM_FEATURE && wcr[WPCA_ESF_BIT];
        // Reserved masks treated as disabled to avoid a second mask path
        wire logic msk_bad = msk != 5'h00 && msk < WPCA_MSK_MIN;
        wire logic [63:0] amask = ~((64'h1 << msk) - 64'h1);
        wire logic a_eq = msk == 5'h00 ? acc_addr_i[63:3] == wvr[63:3]
                        : ((acc_addr_i ^ wvr) & amask) == 64'h0;
        // Upper address half watched through low lanes only
        wire logic [7:0] lanes = wvr[2] ? {bls[3:0], 4'h0} : bls;
        wire logic l_ok = msk != 5'h00 || (lanes & acc_lanes_i) != 8'h0;
        wire logic d_ok = acc_store_i ? ads[1] : ads[0];
        wire logic p_ok = (acc_el_i == WPCA_EL_USER && pf[1])
                       || (acc_el_i == WPCA_EL_KERN && pf[0])
                       || (acc_el_i >= WPCA_EL_HYP && wcr[WPCA_HP_BIT]);
        wire logic s_ok = esf ? acc_realm_i
                        : (ssf == 2'h1 ? !acc_secure_i
                        : ssf == 2'h2 ? acc_secure_i : 1'b1);
        wire logic k_ok = !wcr[WPCA_WLS_BIT] || ctx_match_i[lbi];
        assign hit_d[g] = acc_valid_i && wcr[WPCA_EN_BIT] && !msk_bad
                       && a_eq && l_ok && d_ok && p_ok && s_ok && k_ok;
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rsp_q <= '0;
            hit_q <= '0;
        end else begin
            rsp_q <= rsp_d;
            hit_q <= hit_d;
        end
    end

    assign rsp_o    = rsp_q;
    assign wp_hit_o = hit_q;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    a_user_undef: assert property (is_acc && cel == WPCA_EL_USER |=> rsp_o.undef)
        else $error("lowest level access not undefined");
    a_fgt_trap: assert property (is_acc && !unimpl && cel == WPCA_EL_KERN && !prio_undef
        && fgt_trap |=> rsp_o.trap && rsp_o.trap_el == WPCA_EL_HYP && rsp_o.ec == 6'h18)
        else $error("fine trap not taken to hypervisor");
    a_hdr_trap: assert property (is_acc && !unimpl && cel == WPCA_EL_KERN && !prio_undef
        && hdr_trap |=> rsp_o.trap && rsp_o.trap_el == WPCA_EL_HYP)
        else $error("route trap not taken");
    a_mon_trap: assert property (is_acc && !unimpl && cel == WPCA_EL_HYP && mon_trap
        && !mon_undef |=> rsp_o.trap && rsp_o.trap_el == WPCA_EL_MON)
        else $error("monitor trap not taken");
    a_mon_level: assert property (is_acc && !unimpl && cel == WPCA_EL_MON
        |=> !rsp_o.trap && rsp_o.halt == $past(halt_hit))
        else $error("monitor level check wrong");
    a_halt_acc: assert property (o_halt && is_acc ##1 1'b1 |-> rsp_o.halt && !rsp_o.trap)
        else $error("halt on access missed");
    a_unimpl: assert property (is_wp && 32'(req_i.index) >= NUM_WP |=> rsp_o.undef)
        else $error("unimplemented index not undefined");
    a_write_rb: assert property (do_wr && is_wp ##1 (is_wp && !req_i.write && o_do
        && req_i.index == $past(req_i.index))
        |=> rsp_o.rdata == ($past(req_i.wdata, 2) & WMASK))
        else $error("write then read mismatch");
    a_ads_off: assert property (hit_d[0] |-> wp_q[0][WPCA_ADS_HI:WPCA_ADS_LO] != 2'h0)
        else $error("zero direction select fired");
    a_one_out: assert property (rsp_o.valid |-> $onehot0({rsp_o.undef, rsp_o.trap, rsp_o.halt}))
        else $error("more than one outcome");

    // Answer checks
    a_prio_undef: assert property (is_acc && mid && prio_undef
        |=> rsp_o.undef && !rsp_o.trap)
        else $error("early undefined not taken");
    a_bad_encode: assert property (req_i.valid && !is_acc
        |=> !rsp_o.valid)
        else $error("foreign encoding answered");
    a_rsp_valid: assert property (1'b1
        |=> rsp_o.valid == $past(is_acc))
        else $error("answer valid misplaced");
    a_refused_data: assert property ($onehot({rsp_o.undef, rsp_o.trap, rsp_o.halt})
        |-> rsp_o.rdata == 64'h0)
        else $error("refused access returned data");
    a_no_trap_ec: assert property (!rsp_o.trap
        |-> rsp_o.ec == 6'h00 && rsp_o.trap_el == WPCA_EL_USER)
        else $error("syndrome shown without trap");
    a_trap_ec: assert property (rsp_o.trap
        |-> rsp_o.ec == WPCA_EC_DBG && rsp_o.trap_el != WPCA_EL_USER)
        else $error("trap without debug class");
    a_hyp_skip: assert property (is_acc && !unimpl && cel == WPCA_EL_HYP && !mon_trap
        |=> !rsp_o.trap)
        else $error("hypervisor level trapped by lower checks");
    a_mon_undef: assert property (is_acc && !unimpl && cel == WPCA_EL_HYP && mon_undef
        && mon_trap |=> rsp_o.undef)
        else $error("halted secure disabled trap not undefined");
    a_halt_gate: assert property (is_acc && !halt_hit
        |=> !rsp_o.halt)
        else $error("halt without halt on access");
    a_resv_zero: assert property (rsp_o.valid && $past(is_wp)
        |-> rsp_o.rdata[63:30] == 34'h0 && rsp_o.rdata[23:21] == 3'h0)
        else $error("reserved bits read nonzero");
    a_esf_off: assert property (rsp_o.valid && $past(is_wp) && !REALM_FEATURE
        |-> !rsp_o.rdata[WPCA_ESF_BIT])
        else $error("extended filter bit without realm feature");

    // Watchpoint 0 fields as the checks below see them
    wire logic [63:0] wcr0 = wp_q[0];
    wire logic [4:0]  msk0 = wcr0[WPCA_MSK_HI:WPCA_MSK_LO];
    a_wr_land: assert property (do_wr && is_wp && req_i.index == 4'h0
        |=> wcr0 == ($past(req_i.wdata) & WMASK))
        else $error("watch write did not land");
    a_mask_rsvd: assert property (msk0 == 5'h01 || msk0 == 5'h02
        |-> !hit_d[0])
        else $error("reserved mask fired");
    a_mask_zero: assert property (hit_d[0] && msk0 == 5'h00
        |-> acc_addr_i[63:3] == watch_value_i[63:3])
        else $error("unmasked address mismatch fired");
    a_mask_high: assert property (hit_d[0] && msk0 >= WPCA_MSK_MIN
        |-> (acc_addr_i >> msk0) == (watch_value_i[63:0] >> msk0))
        else $error("masked address mismatch fired");
    a_lane_low: assert property (hit_d[0] && msk0 == 5'h00 && !watch_value_i[2]
        |-> (acc_lanes_i & wcr0[WPCA_BLS_HI:WPCA_BLS_LO]) != 8'h00)
        else $error("unselected byte fired");
    a_lane_high: assert property (hit_d[0] && msk0 == 5'h00 && watch_value_i[2]
        |-> (acc_lanes_i[7:4] & wcr0[WPCA_BLS_LO+3:WPCA_BLS_LO]) != 4'h0)
        else $error("upper lanes used at bit two");
    a_dir_store: assert property (hit_d[0] && acc_store_i
        |-> wcr0[WPCA_ADS_HI])
        else $error("store fired without store select");
    a_dir_load: assert property (hit_d[0] && !acc_store_i
        |-> wcr0[WPCA_ADS_LO])
        else $error("load fired without load select");
    a_priv_user: assert property (hit_d[0] && acc_el_i == WPCA_EL_USER
        |-> wcr0[WPCA_PF_HI])
        else $error("user access fired without user filter");
    a_priv_kern: assert property (hit_d[0] && acc_el_i == WPCA_EL_KERN
        |-> wcr0[WPCA_PF_LO])
        else $error("kernel access fired without kernel filter");
    a_priv_high: assert property (hit_d[0] && acc_el_i >= WPCA_EL_HYP
        |-> wcr0[WPCA_HP_BIT])
        else $error("higher level fired without perspective bit");
    a_sec_only: assert property (hit_d[0] && !REALM_FEATURE
        && wcr0[WPCA_SSF_HI:WPCA_SSF_LO] == 2'h2 |-> acc_secure_i)
        else $error("secure only filter fired outside secure");
    a_sec_nonsec: assert property (hit_d[0] && !REALM_FEATURE
        && wcr0[WPCA_SSF_HI:WPCA_SSF_LO] == 2'h1 |-> !acc_secure_i)
        else $error("nonsecure only filter fired in secure");
    a_link_ctx: assert property (hit_d[0] && wcr0[WPCA_WLS_BIT]
        |-> ctx_match_i[wcr0[WPCA_LBI_HI:WPCA_LBI_LO]])
        else $error("linked watch fired without context match");
    a_en_off: assert property (!wcr0[WPCA_EN_BIT]
        |-> !hit_d[0])
        else $error("disabled watchpoint fired");
    a_hit_reg: assert property (1'b1
        |=> wp_hit_o == $past(hit_d))
        else $error("hit not registered");
endmodule : wpca_top

// file: bench/wpca_core_model.sv
// Purpose: Pipeline model issuing system register accesses to the block
// Assumes: Caller enters issue and idle at a falling edge
// Notes:   Valid is held between calls so back-to-back requests never glitch
`timescale 1ns/1ps
module wpca_core_model (
    // Clock
    input  wire logic          ref_clk_i,
    // Request to the block
    output wpca_pkg::wpca_req_s req_o,
    output logic [1:0]         el_o
);
    import wpca_pkg::*;
    initial begin
        req_o = '0;
        el_o  = WPCA_EL_USER;
    end
    task automatic issue(input logic w, input logic [1:0] el, input logic [2:0] op2,
                         input logic [3:0] idx, input logic [63:0] d);
        req_o = '{1'b1, w, WPCA_OP0, WPCA_OP1, WPCA_CRN, idx, op2, d};
        el_o  = el;
        @(negedge ref_clk_i);
    endtask : issue
    task automatic idle();
        req_o.valid = 1'b0;
    endtask : idle
endmodule : wpca_core_model

// file: bench/testbench.sv
// Purpose: Self-checking bench for the watchpoint control access block
// Assumes: Inputs change at falling edges, answers checked at the next falling edge
// Notes:   Register contents after reset are never relied on
`timescale 1ns/1ps
module testbench;
    import wpca_pkg::*;
    logic          ref_clk_i, sys_rst_i, halted, sdd, mon, hoa, osl, hyp_en, have_mon;
    logic [1:0]    route, fr, fw, el, acc_el;
    logic          acc_valid, acc_store;
    logic [63:0]   acc_addr;
    logic [7:0]    acc_lanes, hit;
    logic [511:0]  wv;
    logic          fte, acc_sec;
    logic [15:0]   ctx;
    wpca_req_s     req;
    wpca_rsp_s     rsp;
    int            failures = 0;
    int            checks = 0;
    wpca_core_model i_wpca_core_model (.ref_clk_i(ref_clk_i), .req_o(req), .el_o(el));
    wpca_top #(.NUM_WP(8)) i_wpca_top (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .req_i(req),
        .current_exception_level_i(el), .rsp_o(rsp), .halted_i(halted),
        .halting_allowed_i(1'b1), .have_monitor_level_i(have_mon), .hyp_enabled_i(hyp_en),
        .secure_debug_disable_i(sdd), .monitor_debug_trap_i(mon),
        .hypervisor_debug_route_trap_i(route), .fine_trap_enable_i(fte),
        .fine_read_trap_reg_i(fr), .fine_write_trap_reg_i(fw), .os_lock_flag_i(osl),
        .halt_on_access_i(hoa), .acc_valid_i(acc_valid), .acc_addr_i(acc_addr),
        .acc_lanes_i(acc_lanes), .acc_store_i(acc_store), .acc_el_i(acc_el),
        .acc_secure_i(acc_sec), .acc_realm_i(1'b0), .watch_value_i(wv),
        .ctx_match_i(ctx), .wp_hit_o(hit));
    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    task automatic complete_run();
        if (failures == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run
    // Expected e is {undef, trap, trap level, halt}
    task automatic cmp_rsp(input logic [4:0] e, input logic [63:0] d);
        checks++;
        if ({rsp.valid, rsp.undef, rsp.trap, rsp.trap_el, rsp.halt, rsp.ec, rsp.rdata} !==
            {1'b1, e, e[3] ? WPCA_EC_DBG : 6'h00, d}) begin
            failures++;
            $display("[ERR] %0t response mismatch", $time);
        end
    endtask : cmp_rsp
    task automatic cmp_hit(input logic e);
        checks++;
        if (hit[0] !== e) begin
            failures++;
            $display("[ERR] %0t watch hit mismatch", $time);
        end
    endtask : cmp_hit
    task automatic cmp_none();
        checks++;
        if (rsp.valid !== 1'b0) begin
            failures++;
            $display("[ERR] %0t foreign encoding answered", $time);
        end
    endtask : cmp_none
    // Config c is {halted, sdd, mon, route, fine, hoa, osl, hyp_en, have_mon}
    task automatic t(input logic [10:0] c, input logic w, input logic [1:0] l,
                     input logic [2:0] o, input logic [3:0] ix, input logic [4:0] e);
        {halted, sdd, mon, route, fr, hoa, osl, hyp_en, have_mon} = c;
        fw = fr;
        i_wpca_core_model.issue(w, l, o, ix, 64'hFFFF_FFFF_FFFF_FFFF);
        cmp_rsp(e, (e == 5'h00 && !w) ? WPCA_WMASK_BASE : 64'h0);
        i_wpca_core_model.idle();
        @(negedge ref_clk_i);
    endtask : t
    // Program watchpoint 0, then probe it with the access level, direction and lanes the caller has set
    task automatic wp(input logic [63:0] d, input logic e);
        {hoa, osl} = 2'b00;
        i_wpca_core_model.issue(1'b1, WPCA_EL_MON, WPCA_OP2_WP, 4'h0, d);
        i_wpca_core_model.idle();
        acc_valid = 1'b1;
        @(negedge ref_clk_i);
        acc_valid = 1'b0;
        cmp_hit(e);
        @(negedge ref_clk_i);
    endtask : wp
    // A neighbouring encoding must stay unanswered
    task automatic foreign_op();
        i_wpca_core_model.issue(1'b0, WPCA_EL_KERN, 3'h6, 4'h2, 64'h0);
        cmp_none();
        i_wpca_core_model.idle();
        @(negedge ref_clk_i);
    endtask : foreign_op
    initial begin
        #100_000;
        failures++;
        complete_run();
    end
    initial begin
        sys_rst_i = 1'b1;
        {halted, sdd, mon, route, fr, fw, hoa, osl, hyp_en, have_mon} = '0;
        {acc_valid, acc_store, acc_lanes, acc_el} = {2'b00, 8'h01, WPCA_EL_KERN};
        acc_addr = 64'h0000_0000_0000_1000;
        wv = {448'h0, acc_addr};
        {fte, acc_sec, ctx} = {1'b1, 1'b0, 16'h0000};
        repeat (4) @(negedge ref_clk_i);
        sys_rst_i = 1'b0;
        // Write then read back to back; reserved bits drop out
        i_wpca_core_model.issue(1'b1, 2'h3, WPCA_OP2_WP, 4'h2, '1);
        cmp_rsp(5'h00, 64'h0);
        t(11'h003, 0, 1, WPCA_OP2_WP, 4'h2, 5'b00000);
        t(11'h003, 0, 0, WPCA_OP2_WP, 4'h2, 5'b10000);
        t(11'h003, 0, 1, WPCA_OP2_WP, 4'h9, 5'b10000);
        t(11'h023, 0, 1, WPCA_OP2_WP, 4'h2, 5'b01100);
        t(11'h023, 1, 1, WPCA_OP2_WP, 4'h2, 5'b01100);
        t(11'h021, 0, 1, WPCA_OP2_WP, 4'h2, 5'b00000);
        t(11'h013, 0, 1, WPCA_OP2_BP, 4'h2, 5'b01100);
        t(11'h043, 0, 1, WPCA_OP2_WP, 4'h2, 5'b01100);
        t(11'h0C3, 0, 2, WPCA_OP2_WP, 4'h2, 5'b00000);
        t(11'h103, 0, 1, WPCA_OP2_WP, 4'h2, 5'b01110);
        t(11'h703, 0, 2, WPCA_OP2_WP, 4'h2, 5'b10000);
        t(11'h1C3, 0, 3, WPCA_OP2_WP, 4'h2, 5'b00000);
        t(11'h00B, 0, 1, WPCA_OP2_WP, 4'h2, 5'b00001);
        t(11'h00F, 0, 1, WPCA_OP2_WP, 4'h2, 5'b00000);
        t(11'h10B, 0, 3, WPCA_OP2_WP, 4'h2, 5'b00001);
        foreign_op();
        // Fine traps need the enable only when the monitor level exists
        fte = 1'b0;
        t(11'h023, 0, 1, WPCA_OP2_WP, 4'h2, 5'b00000);
        t(11'h022, 0, 1, WPCA_OP2_WP, 4'h2, 5'b01100);
        fte = 1'b1;
        // Lanes are kept contiguous and nonzero in every pattern below
        wp(64'h0000_0000_0000_1FFF, 1'b1);
        wp(64'h0000_0000_0000_1FFE, 1'b0);
        wp(64'h0000_0000_0000_1FE7, 1'b0);
        wp(64'h0000_0000_0000_1FF7, 1'b0);
        wp(64'h0000_0000_0100_1FFF, 1'b0);
        wp(64'h0000_0000_0000_005F, 1'b0);
        wp(64'h0000_0000_0000_1FFB, 1'b1);
        acc_el = WPCA_EL_USER;
        wp(64'h0000_0000_0000_1FFB, 1'b0);
        wp(64'h0000_0000_0000_1FFD, 1'b1);
        acc_el = WPCA_EL_KERN;
        acc_store = 1'b1;
        wp(64'h0000_0000_0000_1FF7, 1'b1);
        acc_store = 1'b0;
        wp(64'h0000_0000_0000_9FFF, 1'b0);
        acc_sec = 1'b1;
        wp(64'h0000_0000_0000_9FFF, 1'b1);
        acc_sec = 1'b0;
        wp(64'h0000_0000_0013_1FFF, 1'b0);
        ctx = 16'h0008;
        wp(64'h0000_0000_0013_1FFF, 1'b1);
        ctx = 16'h0000;
        // Address off the watched doubleword, reached only through the mask
        acc_addr = 64'h0000_0000_0000_100C;
        wp(64'h0000_0000_0400_1FFF, 1'b1);
        wp(64'h0000_0000_0300_1FFF, 1'b0);
        complete_run();
    end
endmodule : testbench
